//--- src/mbp_bus_port.sv
// mbp_bus_port.sv: external bus cycle sequencer, 8-bit multiplexed lanes.
// assumes request inputs synchronous to core_clk_in; one cycle per request.
`timescale 1ns/10ps
`include "mbp_cfg.svh"
module mbp_bus_port
  import mbp_pkg::*;
(
  input  wire logic        core_clk_in,              // 250 MHz core clock
  input  wire logic        rst_n_in,                 // sync reset, active low
  input  wire logic        req_valid_in,             // core requests a cycle
  input  wire logic [2:0]  req_kind_in,              // status code of request
  input  wire logic [19:0] req_addr_in,              // cycle address
  input  wire logic [7:0]  req_wdata_in,             // write data
  input  wire logic [19:0] ucs_base_in,              // chip select range low
  input  wire logic [19:0] ucs_limit_in,             // chip select range high
  input  wire logic        ucs_ign_ready_in,         // ignore ready in range
  input  wire logic        ready_in,                 // far side ends cycle
  input  wire logic [7:0]  shared_addr_data_lane_in, // lane input
  output logic             req_ready_out,            // request accepted
  output logic             rsp_valid_out,            // cycle done pulse
  output logic [7:0]       rsp_rdata_out,            // read data
  output logic [11:0]      upper_addr_bit_out,       // address 19..8
  output logic [7:0]       shared_addr_data_lane_out,// lane output
  output logic             shared_addr_data_lane_oe_out, // lane drive enable
  output logic             ale_out,                  // address latch strobe
  output logic             rd_n_out,                 // read strobe
  output logic             wr_n_out,                 // write strobe
  output logic             den_n_out,                // transceiver enable
  output logic             dt_r_n_out,               // direction, high=transmit
  output logic [2:0]       cycle_status_code_out,    // cycle type
  output logic             ucs_n_out                 // upper chip select
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  mbp_state_t  state_r, state_nxt;
  logic [19:0] addr_r;
  logic [7:0]  wdata_r;
  mbp_status_t kind_r;
  logic        ucs_hit;
  logic        ucs_hit_nxt;

  // read and write kinds, shared by the strobes and by their checks
  function automatic logic mbp_reads(input mbp_status_t k);
    return (k == `MBP_ST_IORD) || (k == `MBP_ST_MEMRD) || (k == `MBP_ST_FETCH)
           || (k == `MBP_ST_INTA);
  endfunction
  function automatic logic mbp_writes(input mbp_status_t k);
    return (k == `MBP_ST_IOWR) || (k == `MBP_ST_MEMWR);
  endfunction

  wire         take      = (state_r == MBP_IDLE) && req_valid_in && (req_kind_in != `MBP_ST_IDLE);
  wire         is_write  = mbp_writes(kind_r);
  wire         is_read   = mbp_reads(kind_r);
  wire         is_mem    = kind_r[2];
  // halt has no data transfer, so it needs no ready
  wire         no_xfer   = (kind_r == `MBP_ST_HALT);
  wire         done      = no_xfer || ready_in || (ucs_hit && ucs_ign_ready_in);
  // pins are computed from the next state so they line up with state_r
  wire [2:0]   nk        = take ? req_kind_in : kind_r;
  wire [19:0]  na        = take ? req_addr_in : addr_r;
  wire         nk_mem    = nk[2] && (nk != `MBP_ST_IDLE);

  mbp_ucs_decode i_mbp_ucs_decode
  (
    .addr_in   (addr_r),
    .is_mem_in (is_mem),
    .base_in   (ucs_base_in),
    .limit_in  (ucs_limit_in),
    .hit_out   (ucs_hit)
  );
  // second copy looks at the next address so the select pin can be registered
  mbp_ucs_decode i_mbp_ucs_decode_nxt
  (
    .addr_in   (na),
    .is_mem_in (nk_mem),
    .base_in   (ucs_base_in),
    .limit_in  (ucs_limit_in),
    .hit_out   (ucs_hit_nxt)
  );

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      MBP_IDLE: if (take) state_nxt = MBP_ADDR;
      MBP_ADDR: state_nxt = MBP_DATA;
      MBP_DATA: if (done) state_nxt = MBP_END;
      MBP_END:  state_nxt = MBP_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer and registered pins
  // ------------------------------------------------------------
  wire in_addr = (state_nxt == MBP_ADDR);
  wire in_data = (state_nxt == MBP_DATA);
  wire in_cyc  = (state_nxt != MBP_IDLE);

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= MBP_IDLE;
      addr_r  <= 20'h0_0000;
      wdata_r <= 8'h00;
      kind_r  <= `MBP_ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
      if (take)
      begin
        addr_r  <= req_addr_in;
        wdata_r <= req_wdata_in;
        kind_r  <= req_kind_in;
      end
    end
  end

  // strobe conditions, decoded once for the pins below
  wire rd_act  = in_data && is_read;
  wire wr_act  = in_data && is_write;
  wire den_act = in_data && !no_xfer;
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      req_ready_out                <= 1'b0;
      rsp_valid_out                <= 1'b0;
      rsp_rdata_out                <= 8'h00;
      upper_addr_bit_out           <= 12'h000;
      shared_addr_data_lane_out    <= 8'h00;
      shared_addr_data_lane_oe_out <= 1'b0;
      ale_out                      <= 1'b0;
      rd_n_out                     <= 1'b1;
      wr_n_out                     <= 1'b1;
      den_n_out                    <= 1'b1;
      dt_r_n_out                   <= 1'b1;
      cycle_status_code_out        <= `MBP_ST_IDLE;
      ucs_n_out                    <= 1'b1;
    end
    else
    begin
      req_ready_out <= take;
      rsp_valid_out <= (state_r == MBP_DATA) && done;
      if ((state_r == MBP_DATA) && done && is_read)
        rsp_rdata_out <= shared_addr_data_lane_in;
      if (in_cyc)
        upper_addr_bit_out <= na[19:`MBP_UPPER_LSB];
      shared_addr_data_lane_out <= in_addr ? na[7:0] : wdata_r;
      shared_addr_data_lane_oe_out <= in_addr || (in_data && is_write);
      ale_out  <= in_addr;
      rd_n_out <= !rd_act;
      wr_n_out <= !wr_act;
      den_n_out <= !den_act;
      dt_r_n_out <= !(in_cyc && is_read && !in_addr);
      cycle_status_code_out <= in_cyc && (state_nxt != MBP_END) ? nk : `MBP_ST_IDLE;
      ucs_n_out <= !(in_cyc && (state_nxt != MBP_END) && ucs_hit_nxt);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_addr_phase;
    ale_out && shared_addr_data_lane_oe_out;
  endsequence
  sequence s_data_phase;
    !ale_out;
  endsequence

  a_ale_then_data: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ale_out |-> s_addr_phase ##1 s_data_phase)
    else $error("latch strobe not followed by data phase");
  a_upper_stable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!ale_out && cycle_status_code_out != `MBP_ST_IDLE && $past(cycle_status_code_out) != `MBP_ST_IDLE)
    |-> $stable(upper_addr_bit_out))
    else $error("upper address moved inside a cycle");
  a_wr_data_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !wr_n_out |-> shared_addr_data_lane_oe_out && !den_n_out)
    else $error("write strobe without driven data");
  a_rd_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !rd_n_out |-> !shared_addr_data_lane_oe_out && wr_n_out)
    else $error("lanes driven during read");
  a_rd_den: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !rd_n_out |-> !den_n_out && !dt_r_n_out)
    else $error("read without transceiver enable");
  a_den_only_xfer: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !den_n_out |-> (!rd_n_out || !wr_n_out))
    else $error("transceiver enabled with no transfer");
  a_wait_ready: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == MBP_DATA && !ready_in && !no_xfer && !(ucs_hit && ucs_ign_ready_in))
    |=> state_r == MBP_DATA)
    else $error("cycle ended without ready");
  a_ucs_io: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !ucs_n_out |-> cycle_status_code_out[2] && cycle_status_code_out != `MBP_ST_IDLE)
    else $error("chip select outside memory cycle");
  a_status_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == MBP_IDLE) |-> cycle_status_code_out == `MBP_ST_IDLE)
    else $error("status not idle between cycles");
  a_lane_addr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ale_out |-> shared_addr_data_lane_out == addr_r[7:0])
    else $error("low address missing in address phase");

  sequence s_read_open;
    !rd_n_out && !den_n_out;
  endsequence
  sequence s_read_close;
    rd_n_out && den_n_out && rsp_valid_out;
  endsequence

  a_read_close: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_read_open ##1 (state_r == MBP_END) |-> s_read_close)
    else $error("read strobe not closed with the response");
  a_status_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !rd_n_out |-> mbp_reads(cycle_status_code_out))
    else $error("read strobe under a non-read status");
  a_status_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !wr_n_out |-> mbp_writes(cycle_status_code_out))
    else $error("write strobe under a non-write status");
  a_status_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ale_out |=> $stable(cycle_status_code_out))
    else $error("status changed after the address phase");
  a_ucs_match: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == MBP_DATA) |-> (ucs_n_out != ucs_hit))
    else $error("chip select disagrees with the range");
  a_rsp_ready: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_r == MBP_DATA && ready_in) |=> rsp_valid_out)
    else $error("ready seen but cycle not ended");
endmodule

//--- src/mbp_cfg.svh
// mbp_cfg.svh: constants of the multiplexed 8-bit external bus port.
// assumes a 250 MHz core clock; included by its bare name.
// What this block does
// - upper twelve address bits held whole cycle
// - low lanes carry address, then data
// - latch strobe high during address phase
// - write strobe low while write data valid
// - upper chip select low for memory cycles inside range
// - read strobe low; device drives data
// - cycle waits for ready unless ignored or a halt cycle
// - three-bit status code for each cycle
// - transceiver enable low only during transfer
`ifndef MBP_CFG_SVH
`define MBP_CFG_SVH
`define MBP_ST_INTA   3'h0
`define MBP_ST_IORD   3'h1
`define MBP_ST_IOWR   3'h2
`define MBP_ST_HALT   3'h3
`define MBP_ST_FETCH  3'h4
`define MBP_ST_MEMRD  3'h5
`define MBP_ST_MEMWR  3'h6
`define MBP_ST_IDLE   3'h7
`define MBP_UCS_RST_BASE 20'hF_0000
`define MBP_ADDR_W    20
`define MBP_UPPER_LSB 8
`endif

//--- src/mbp_pkg.sv
// mbp_pkg.sv: types shared by the bus port modules.
// assumes mbp_cfg.svh is on the include path.
package mbp_pkg;
  typedef enum logic [1:0]
  {
    MBP_IDLE  = 2'b00,
    MBP_ADDR  = 2'b01,
    MBP_DATA  = 2'b11,
    MBP_END   = 2'b10
  } mbp_state_t;
  typedef logic [2:0] mbp_status_t;
endpackage

//--- src/mbp_ucs_decode.sv
// mbp_ucs_decode.sv: upper chip select range match.
// assumes base/limit are stable while a cycle is open.
`timescale 1ns/10ps
`include "mbp_cfg.svh"
module mbp_ucs_decode
  import mbp_pkg::*;
(
  input  wire logic [19:0] addr_in,     // cycle address
  input  wire logic        is_mem_in,   // cycle targets memory
  input  wire logic [19:0] base_in,     // lowest selected address
  input  wire logic [19:0] limit_in,    // highest selected address
  output logic             hit_out      // address in range
);
  // io cycles never select upper memory
  assign hit_out = is_mem_in && (addr_in >= base_in) && (addr_in <= limit_in);
endmodule

//--- sim/mbp_far_mem.sv
// mbp_far_mem.sv: byte memory on the far side of the bus port.
// assumes the bench resolves the lane wire and feeds it back here.
`timescale 1ns/10ps
module mbp_far_mem
(
  input  wire logic       clk_in,    // core clock
  input  wire logic       ale_in,    // address strobe
  input  wire logic       rd_n_in,   // read strobe
  input  wire logic       wr_n_in,   // write strobe
  input  wire logic [7:0] lane_in,   // wire level
  input  wire logic [3:0] wait_in,   // wait states
  input  wire logic       stall_in,  // hold ready low
  output logic            ready_out, // ends cycle
  output logic            drv_out,   // drives lane
  output logic [7:0]      data_out   // read byte
);
  logic [7:0] mem_r [256];
  logic [7:0] adr_r;
  logic [3:0] cnt_r;
  always @(posedge clk_in)
  begin
    if (ale_in) adr_r <= lane_in;
    if (!wr_n_in) mem_r[adr_r] <= lane_in;
    cnt_r <= (rd_n_in && wr_n_in) ? 4'h0 : cnt_r + 4'h1;
  end
  // ready idles high; the port must not end a cycle on it outside a strobe
  assign ready_out = !stall_in && ((rd_n_in && wr_n_in) || cnt_r >= wait_in);
  assign drv_out   = !rd_n_in;
  assign data_out  = mem_r[adr_r];
endmodule

//--- sim/mbp_bus_port_tb_top.sv
// mbp_bus_port_tb_top.sv: self-checking bench for the bus port.
// assumes mbp_far_mem as far side; released lane shows inverse of last.
`timescale 1ns/10ps
`include "mbp_cfg.svh"
module mbp_bus_port_tb_top;
  logic clk = 0, rst_n = 0, vld = 0, ign = 0, stall = 0;
  logic [2:0] kind = 0, st;
  logic [19:0] adr = 0;
  logic [7:0] wd = 0, got, rdat, lo, md, last_r = 0;
  logic [3:0] wt = 0;
  logic [19:0] ucs_lo = 20'hf_0000, ucs_hi = 20'hf_ffff;
  logic [11:0] up;
  logic rq_rdy, rsp, oe, ale, rd_n, wr_n, den_n, dtr, ucs_n, rdy, drv;
  wire [7:0] lane = oe ? lo : (drv ? md : ~last_r);
  int fail_count = 0, n_compared = 0, rsp_cnt = 0, n0;
  initial forever #2 clk = ~clk;
  always @(posedge clk) last_r <= lane;
  always @(posedge clk) rsp_cnt <= rsp_cnt + int'(rsp === 1'b1);
  mbp_bus_port i_mbp_bus_port (.core_clk_in(clk), .rst_n_in(rst_n), .req_valid_in(vld),
    .req_kind_in(kind), .req_addr_in(adr), .req_wdata_in(wd), .ucs_base_in(ucs_lo),
    .ucs_limit_in(ucs_hi), .ucs_ign_ready_in(ign), .ready_in(rdy),
    .shared_addr_data_lane_in(lane), .req_ready_out(rq_rdy), .rsp_valid_out(rsp),
    .rsp_rdata_out(rdat), .upper_addr_bit_out(up), .shared_addr_data_lane_out(lo),
    .shared_addr_data_lane_oe_out(oe), .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .den_n_out(den_n), .dt_r_n_out(dtr), .cycle_status_code_out(st), .ucs_n_out(ucs_n));
  mbp_far_mem i_mbp_far_mem (.clk_in(clk), .ale_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .lane_in(lane), .wait_in(wt), .stall_in(stall), .ready_out(rdy), .drv_out(drv),
    .data_out(md));
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok)
    begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // one whole bus cycle; u is the expected select level, w the wait states
  task automatic cyc(input logic [2:0] k, input logic [19:0] a, input logic [7:0] d,
                     input logic u, input logic [3:0] w);
    int i;
    int n_rd;
    int n_wr;
    bit exp_rd;
    bit exp_wr;
    n_rd = 0;
    n_wr = 0;
    exp_rd = (k == `MBP_ST_INTA) || (k == `MBP_ST_IORD) || (k == `MBP_ST_FETCH)
             || (k == `MBP_ST_MEMRD);
    exp_wr = (k == `MBP_ST_IOWR) || (k == `MBP_ST_MEMWR);
    @(posedge clk);
    vld <= 1'b1;
    kind <= k;
    adr <= a;
    wd <= d;
    wt <= w;
    for (i = 0; i < 8 && rq_rdy !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(ale === 1'b1 && oe === 1'b1 && lo === a[7:0], "address phase");
    chk(st === k && ucs_n === u, "status or select");
    for (i = 0; i < 40 && rsp !== 1'b1; i++)
    begin
      @(posedge clk);
      vld <= 1'b0;
      #1;
      chk(up === a[19:8] && ale === 1'b0, "upper address");
      chk(rsp === 1'b1 || st === k, "status in data phase");
      if (rd_n === 1'b0)
      begin
        n_rd++;
        chk(oe === 1'b0 && den_n === 1'b0 && dtr === 1'b0, "read lanes");
      end
      if (wr_n === 1'b0)
      begin
        n_wr++;
        chk(oe === 1'b1 && lo === d && den_n === 1'b0, "write lanes");
        chk(dtr === 1'b1, "write direction");
      end
    end
    got = rdat;
    chk(rsp === 1'b1 && st === `MBP_ST_IDLE && den_n === 1'b1, "cycle end");
    chk((n_rd > 0) == exp_rd && (n_wr > 0) == exp_wr, "strobe for kind");
    // with ready honoured, the strobe stands one cycle more than the wait states
    if (ign === 1'b0 && (exp_rd || exp_wr))
      chk(n_rd + n_wr == int'(w) + 1, "wait states");
  endtask
  task t_rw;
    cyc(`MBP_ST_MEMWR, 20'h1_23a5, 8'h5a, 1'b1, 4'h0);
    cyc(`MBP_ST_IOWR, 20'h0_0001, 8'hc3, 1'b1, 4'h2);
    cyc(`MBP_ST_MEMRD, 20'h1_23a5, 8'h00, 1'b1, 4'h3);
    chk(got === 8'h5a, "memory read back");
    cyc(`MBP_ST_IORD, 20'h0_0001, 8'h00, 1'b1, 4'h0);
    chk(got === 8'hc3, "io read back");
    $display("test rw done");
  endtask
  task t_kinds;
    for (int k = 0; k < 7; k++)
      cyc(3'(k), 20'h2_0000 + 20'(k), 8'h11, 1'b1, 4'h1);
    @(posedge clk);
    vld <= 1'b1;
    kind <= `MBP_ST_IDLE;
    repeat (6)
    begin
      @(posedge clk);
      #1 chk(rq_rdy === 1'b0 && ale === 1'b0, "idle kind taken");
    end
    @(posedge clk);
    vld <= 1'b0;
    $display("test kinds done");
  endtask
  task t_ucs;
    @(posedge clk);
    ign <= 1'b1;
    stall <= 1'b1;
    cyc(`MBP_ST_FETCH, 20'hf_0000, 8'h00, 1'b0, 4'h0);
    fork
      cyc(`MBP_ST_MEMRD, 20'he_ffff, 8'h00, 1'b1, 4'h0);
      begin
        // the fetch's done pulse is counted at this edge
        @(posedge clk);
        #1 n0 = rsp_cnt;
        repeat (11) @(posedge clk);
        #1 chk(rsp_cnt == n0, "ended without ready");
        @(posedge clk);
        stall <= 1'b0;
      end
    join
    @(posedge clk);
    ucs_lo <= 20'h2_0000;
    ucs_hi <= 20'h2_00ff;
    cyc(`MBP_ST_MEMWR, 20'h2_00ff, 8'h77, 1'b0, 4'h0);
    cyc(`MBP_ST_IORD, 20'h2_0000, 8'h00, 1'b1, 4'h0);
    cyc(`MBP_ST_MEMRD, 20'h2_01ff, 8'h00, 1'b1, 4'h0);
    chk(got === 8'h77, "select range read back");
    $display("test select done");
  endtask
  task summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_rw;
    t_kinds;
    t_ucs;
    summarize;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: watchdog", $time);
    summarize;
  end
endmodule
